//--- hdl/sccr_regs.sv
// system control coprocessor register bank
`timescale 1ns/1ps

module sccr_regs
   import sccr_pkg::*;
#(
   parameter logic [7:0] part_kind = 8'h2a, // arbitrary value
   parameter logic [7:0] silicon_step = 8'h01 // arbitrary value
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire sccr_req_type req,
   input wire sccr_exc_type exc,
   output logic [31:0] rdata,
   output logic [31:0] state_word,
   output logic tally_match
);

   initial begin
      if (sccr_tally_w != 24) $error("tally width must be 24");
   end

   typedef struct packed {
      logic [31:0] bus_setup;
      logic [31:0] cpu_setup;
      logic [31:0] fault;
      logic [23:0] tally;
      logic [31:0] width;
      logic [23:0] limit;
      logic [31:0] state;
      logic [31:0] reason;
      logic [31:0] trap;
      logic [31:0] rdata;
      logic match;
   } sccr_state_type;

   sccr_state_type st_ff;
   sccr_state_type nxt_st;
   logic [31:0] ident;

   assign ident = {16'h0000, part_kind, silicon_step};

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.match = 1'b0;
      // tally wraps to zero on reaching the limit
      if (st_ff.tally == st_ff.limit) begin
         nxt_st.tally = sccr_tally_reset;
         nxt_st.match = 1'b1;
      end else begin
         nxt_st.tally = st_ff.tally + 24'h00_0001;
      end
      if (req.to_ctl) begin
         unique case (req.num)
            sccr_num_bus: nxt_st.bus_setup = req.wdata;
            sccr_num_cpu: nxt_st.cpu_setup = req.wdata;
            sccr_num_tally: nxt_st.tally = req.wdata[23:0];
            sccr_num_width: nxt_st.width = req.wdata;
            sccr_num_limit: nxt_st.limit = req.wdata[23:0];
            sccr_num_state: nxt_st.state = req.wdata & sccr_state_wmask;
            // ident and read-only registers keep their value
            default: nxt_st.state = nxt_st.state;
         endcase
      end
      if (req.restore) begin
         nxt_st.state[3:0] = st_ff.state[5:2];
      end
      // an exception outranks a same-cycle software write to state bits 5..0; the written upper bits still land
      if (exc.take) begin
         nxt_st.state[5:0] = {st_ff.state[3:0], sccr_kernel_pair};
         nxt_st.reason = exc.reason;
         nxt_st.trap = exc.ret_addr;
         if (exc.addr_err) begin
            nxt_st.fault = exc.bad_addr;
         end
      end
      nxt_st.rdata = st_ff.rdata;
      if (req.from_ctl) begin
         unique case (req.num)
            sccr_num_bus: nxt_st.rdata = st_ff.bus_setup;
            sccr_num_cpu: nxt_st.rdata = st_ff.cpu_setup;
            sccr_num_fault: nxt_st.rdata = st_ff.fault;
            sccr_num_tally: nxt_st.rdata = {8'h00, st_ff.tally};
            sccr_num_width: nxt_st.rdata = st_ff.width;
            sccr_num_limit: nxt_st.rdata = {8'h00, st_ff.limit};
            sccr_num_state: nxt_st.rdata = st_ff.state;
            sccr_num_reason: nxt_st.rdata = st_ff.reason;
            sccr_num_trap: nxt_st.rdata = st_ff.trap;
            sccr_num_ident: nxt_st.rdata = ident;
            default: nxt_st.rdata = sccr_word_zero;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_ff <= '0;
         st_ff.state <= sccr_state_reset;
         st_ff.limit <= sccr_limit_reset;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata = st_ff.rdata;
   assign state_word = st_ff.state;
   assign tally_match = st_ff.match;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   ident_read_a: assert property (req.from_ctl && req.num == sccr_num_ident |=>
      rdata == ident) else $error("identity read wrong");
   // a read may trail the write by a few idle cycles, as software would issue it
   ident_fixed_a: assert property (req.to_ctl && req.num == sccr_num_ident && !req.from_ctl
      ##[1:4] req.from_ctl && req.num == sccr_num_ident |=> rdata == ident)
      else $error("identity changed by write");
   stack_push_a: assert property (exc.take |=> state_word[5:0] ==
      {$past(state_word[3:0]), sccr_kernel_pair}) else $error("push wrong");
   stack_pop_a: assert property (req.restore && !exc.take |=>
      state_word[3:0] == $past(state_word[5:2])) else $error("pop wrong");
   fault_cap_a: assert property (exc.take && exc.addr_err |=>
      st_ff.fault == $past(exc.bad_addr)) else $error("fault address lost");
   tally_inc_a: assert property (st_ff.tally != st_ff.limit && !req.to_ctl |=>
      st_ff.tally == $past(st_ff.tally) + 24'h00_0001) else $error("tally stuck");
   tally_wrap_a: assert property (st_ff.tally == st_ff.limit && !req.to_ctl |=>
      tally_match && st_ff.tally == sccr_tally_reset) else $error("wrap missing");
   zero_bits_a: assert property (req.from_ctl && req.num == sccr_num_tally |=>
      rdata[31:24] == 8'h00) else $error("zero field nonzero");
   state_write_a: assert property (req.to_ctl && req.num == sccr_num_state && !exc.take
      && !req.restore |=> state_word == ($past(req.wdata) & sccr_state_wmask))
      else $error("state write lost");
   trap_cap_a: assert property (exc.take |=> st_ff.trap == $past(exc.ret_addr)
      && st_ff.reason == $past(exc.reason)) else $error("trap capture wrong");
   // numbers above the identity register decode to nothing and must read as zero
   unmapped_read_a: assert property (req.from_ctl && req.num > sccr_num_ident |=>
      rdata == sccr_word_zero) else $error("unmapped read nonzero");
   limit_zero_a: assert property (req.from_ctl && req.num == sccr_num_limit |=>
      rdata[31:24] == 8'h00) else $error("limit zero field nonzero");
   // the faulting address is only ever loaded by hardware, never by software
   fault_hold_a: assert property (!(exc.take && exc.addr_err) |=>
      st_ff.fault == $past(st_ff.fault)) else $error("fault address overwritten");
   match_cause_a: assert property (tally_match |->
      $past(st_ff.tally == st_ff.limit)) else $error("match without limit hit");

   wrap_c: cover property (tally_match);
   push_pop_c: cover property (exc.take ##[1:4] req.restore);
   nested_c: cover property (exc.take ##1 exc.take);
   fault_c: cover property (exc.take && exc.addr_err);
   state_wr_c: cover property (req.to_ctl && req.num == sccr_num_state);
endmodule

//--- shared/sccr_pkg.sv
// constants and carrier types for the system control register bank
package sccr_pkg;
   localparam int sccr_addr_w = 5;
   localparam logic [4:0] sccr_num_bus = 5'h02;
   localparam logic [4:0] sccr_num_cpu = 5'h03;
   localparam logic [4:0] sccr_num_fault = 5'h08;
   localparam logic [4:0] sccr_num_tally = 5'h09;
   localparam logic [4:0] sccr_num_width = 5'h0a;
   localparam logic [4:0] sccr_num_limit = 5'h0b;
   localparam logic [4:0] sccr_num_state = 5'h0c;
   localparam logic [4:0] sccr_num_reason = 5'h0d;
   localparam logic [4:0] sccr_num_trap = 5'h0e;
   localparam logic [4:0] sccr_num_ident = 5'h0f;
   // writable bits of the state register: unit usable, byte flip, 22..16, mode stack
   localparam logic [31:0] sccr_state_wmask = 32'hf27f_003f;
   // lookup_double_hit_halt is set by reset: no translation hardware here
   localparam logic [31:0] sccr_state_reset = 32'h0060_0002;
   localparam int sccr_ident_kind_lsb = 8;
   localparam int sccr_tally_w = 24;
   localparam logic [23:0] sccr_tally_reset = 24'h00_0000;
   localparam logic [23:0] sccr_limit_reset = 24'hff_ffff;
   localparam logic [31:0] sccr_word_zero = 32'h0000_0000;
   localparam logic [1:0] sccr_kernel_pair = 2'h2; // mode=kernel, interrupts off

   // instruction-side request carrier
   typedef struct packed {
      logic to_ctl;
      logic from_ctl;
      logic restore;
      logic [4:0] num;
      logic [31:0] wdata;
   } sccr_req_type;

   // exception-side event carrier
   typedef struct packed {
      logic take;
      logic [31:0] reason;
      logic [31:0] ret_addr;
      logic addr_err;
      logic [31:0] bad_addr;
   } sccr_exc_type;
endpackage

//--- verif/tb_sccr_regs.sv
// self-checking bench for the system control register bank
`timescale 1ns/1ps
module tb_sccr_regs;
   import sccr_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   sccr_req_type req = '0;
   sccr_exc_type exc = '0;
   logic [31:0] rdata, state_word;
   logic tally_match;
   int n_mismatch = 0;
   int checked = 0;
   int n;
   sccr_regs i_sccr_regs (.ref_clk(ref_clk), .resetn(resetn), .req(req), .exc(exc),
      .rdata(rdata), .state_word(state_word), .tally_match(tally_match));
   always #4 ref_clk = ~ref_clk;
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one strobe cycle; rdata has already settled when the task returns
   task automatic acc(logic wr, logic rd, logic rs, logic [4:0] num, logic [31:0] wd);
      @(posedge ref_clk);
      req <= {wr, rd, rs, num, wd};
      @(posedge ref_clk);
      req <= '0;
      #1;
   endtask
   task automatic rd_chk(string nm, logic [4:0] num, logic [31:0] exp);
      acc(1'b0, 1'b1, 1'b0, num, 32'h0);
      chk(nm, rdata, exp);
   endtask
   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_ident();
      chk("state reset", state_word, sccr_state_reset);
      rd_chk("ident", sccr_num_ident, 32'h0000_2a01);
      acc(1'b1, 1'b0, 1'b0, sccr_num_ident, 32'h0000_ffff);
      rd_chk("ident after write", sccr_num_ident, 32'h0000_2a01);
      rd_chk("unmapped", 5'h1f, 32'h0);
      $display("test ident done");
   endtask
   task automatic t_rw();
      logic [4:0] nums [3] = '{sccr_num_bus, sccr_num_cpu, sccr_num_width};
      foreach (nums[i]) begin
         acc(1'b1, 1'b0, 1'b0, nums[i], 32'h5a5a_0000 | 32'(i));
         rd_chk("setup reg", nums[i], 32'h5a5a_0000 | 32'(i));
      end
      acc(1'b1, 1'b0, 1'b0, sccr_num_state, 32'hf27f_003f);
      chk("state mask", state_word, 32'hf27f_003f);
      rd_chk("state read", sccr_num_state, 32'hf27f_003f);
      acc(1'b1, 1'b0, 1'b0, sccr_num_state, sccr_state_reset);
      $display("test rw done");
   endtask
   task automatic t_trap();
      @(posedge ref_clk);
      exc <= {1'b1, 32'h0000_0010, 32'h8000_0180, 1'b1, 32'h0000_1003};
      @(posedge ref_clk);
      exc <= '0;
      #1;
      chk("push", state_word, 32'h0060_000a);
      rd_chk("reason", sccr_num_reason, 32'h0000_0010);
      rd_chk("return", sccr_num_trap, 32'h8000_0180);
      acc(1'b1, 1'b0, 1'b0, sccr_num_fault, 32'h0);
      rd_chk("fault", sccr_num_fault, 32'h0000_1003);
      acc(1'b0, 1'b0, 1'b1, 5'h0, 32'h0);
      chk("pop", state_word, sccr_state_reset);
      $display("test trap done");
   endtask
   task automatic t_tally();
      acc(1'b1, 1'b0, 1'b0, sccr_num_tally, 32'h00ab_cdef);
      rd_chk("tally", sccr_num_tally, 32'h00ab_cdf0);
      acc(1'b1, 1'b0, 1'b0, sccr_num_limit, 32'h0000_0003);
      rd_chk("limit", sccr_num_limit, 32'h0000_0003);
      acc(1'b1, 1'b0, 1'b0, sccr_num_tally, 32'h0);
      n = 0;
      // bounded wait: tally runs 0..3, pulse lands one edge later
      while (tally_match !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk("match delay", 32'(n), 32'h4);
      @(posedge ref_clk);
      #1;
      chk("match pulse", 32'(tally_match), 32'h0);
      $display("test tally done");
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      t_ident();
      t_rw();
      t_trap();
      t_tally();
      conclude();
   end
   initial begin
      #20000;
      n_mismatch++;
      conclude();
   end
endmodule
